// file: rtl/crs_pkg.sv
package crs_pkg;
    // ----------------------------------------
    // timing, in the units they are specified in
    // ----------------------------------------
    localparam int CRS_CLK_HZ     = 200_000_000;
    localparam int CRS_BURST_MS   = 3500;
    localparam int CRS_LONG_MS    = 250;
    localparam int CRS_SHORT_MS   = 10;
    localparam int CRS_BAUD       = 2400;
    localparam int CRS_MS_PER_S   = 1000;

    // ----------------------------------------
    // serial frame
    // ----------------------------------------
    localparam logic [7:0] CRS_SYNC_BYTE  = 8'h55;
    localparam logic [4:0] CRS_FRAME_BITS = 5'h14;  // two frames of start, 8 data, stop
    localparam int         CRS_LP_BIT     = 6;

    // ----------------------------------------
    // stage and fault codes
    // ----------------------------------------
    localparam logic [2:0] CRS_STG0      = 3'h0;
    localparam logic [2:0] CRS_STG1      = 3'h1;
    localparam logic [2:0] CRS_STG2      = 3'h2;
    localparam logic [2:0] CRS_STG3      = 3'h3;
    localparam logic [2:0] CRS_STG2_LOW  = 3'h4;
    localparam logic [2:0] CRS_STG_DONE  = 3'h5;
    localparam logic [2:0] CRS_FLT_NONE  = 3'h0;
    localparam logic [2:0] CRS_FLT_DISC  = 3'h1;
    localparam logic [2:0] CRS_FLT_TEMP  = 3'h2;
    localparam logic [2:0] CRS_FLT_TIMER = 3'h3;
    localparam logic [2:0] CRS_FLT_UVOLT = 3'h4;

    // ----------------------------------------
    // configuration input thresholds, 8-bit codes of full scale
    // ----------------------------------------
    localparam logic [7:0] CRS_CFG_LOW   = 8'h0A;   // about 4 %
    localparam logic [7:0] CRS_CFG_HIGH  = 8'hF5;   // about 96 %
    localparam logic [7:0] CRS_CFG_MID   = 8'h80;   // 50 %
    localparam logic [9:0] CRS_S3_RATIO  = 10'h3CC; // 97.2 % in permille

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [3:0] CRS_REG_CTRL = 4'h0;
    localparam logic [3:0] CRS_REG_STAT = 4'h4;

    typedef enum logic [1:0] {CRS_IDLE, CRS_PULSE, CRS_UART, CRS_GAP} crs_phase_t;

    typedef struct packed {
        logic       wide_temp;
        logic       stage3_en;
        logic       temp_comp_en;
        logic       time_lim_en;
    } crs_cfg_t;

    typedef struct packed {
        crs_phase_t  ph;
        logic [31:0] burst;
        logic [31:0] tmr;
        logic [31:0] width;
        logic [2:0]  left;
        logic        sent;
        logic [19:0] sh;
        logic [4:0]  nbit;
        logic [31:0] baud;
        logic [31:0] ftmr;
        logic [2:0]  fleft;
        logic        stat;
        logic        flt;
        logic        restart;
        logic        s2_hold;
        logic        en;
        logic [7:0]  last;
        logic [31:0] rdata;
        crs_cfg_t    cfg;
    } crs_state_t;
endpackage

// file: rtl/crs_reporter.sv
`timescale 1ns/10ps
// How it works
// - a new pulse burst starts every 3.5 s while the charger runs
// - both indicator outputs go high for LED on, low for LED off
// - status pulses: 1x10ms stage0/fault, 1x250ms st1, 2x st2, 3x st3
// - status stays on when done, or stage2 held below C/10 without stage3 and without limits
// - fault output off unless fault; 1 to 4 pulses of 250ms by fault
// - stage 3 without a fault gives three status pulses per burst
// - status output carries a transmit-only serial line, nothing received
// - right after the first pulse send sync byte 0x55 then status byte
// - bytes go out least significant bit first
// - frames are 8 data bits, no parity, one stop bit
// - 2400 baud within ten percent; receiver finds rate from sync byte
// - status byte bit 7 is always zero
// - low power flag is 0 in low power mode, 1 otherwise
// - status byte holds 3-bit stage code and 3-bit fault code
// - both config inputs low: narrow range, no stage3, comp or limits
// - without time limits stage 2 voltage is held indefinitely
// - config a 87.6% and b full: wide range, stage3 97.2%, comp, no limits
// - stage3 without limits restarts below 96% of limit or above C/5
// - only the highest priority fault is reported
module crs_reporter
    import crs_pkg::*;
#(
    parameter int BURST_CYC = CRS_CLK_HZ / CRS_MS_PER_S * CRS_BURST_MS,
    parameter int LONG_CYC  = CRS_CLK_HZ / CRS_MS_PER_S * CRS_LONG_MS,
    parameter int SHORT_CYC = CRS_CLK_HZ / CRS_MS_PER_S * CRS_SHORT_MS,
    parameter int BIT_CYC   = CRS_CLK_HZ / CRS_BAUD
) (
    input  wire logic       clock,              // 200 MHz
    input  wire logic       sys_rst,            // async, active high
    input  wire logic       charger_run,        // charger operating
    input  wire logic [1:0] stage_in,           // present stage 0..3
    input  wire logic       done_in,            // charging done
    input  wire logic [3:0] fault_in,           // disc, temp, timer, undervolt
    input  wire logic       low_power_in,       // in low power mode
    input  wire logic       iout_below_c10,     // output current under C/10
    input  wire logic       iout_above_c5,      // output current over C/5
    input  wire logic       vbat_below_96,      // battery under 96 % of stage3 limit
    input  wire logic [7:0] charge_config_in_a, // config input a, code of full scale
    input  wire logic [7:0] charge_config_in_b, // config input b, code of full scale
    input  wire logic [3:0] reg_addr,           // register byte address
    input  wire logic [31:0] reg_wdata,         // register write data
    input  wire logic       reg_wr,             // write strobe
    input  wire logic       reg_rd,             // read strobe
    output logic [31:0]     reg_rdata,          // read data, cycle after strobe
    output logic            status_out,         // status LED and serial line
    output logic            fault_out,          // fault LED
    output logic            restart_req,        // stage 3 restart request
    output logic            stage2_hold,        // hold stage 2 limit indefinitely
    output logic            wide_temp_range,    // wide valid temperature range
    output logic            stage3_enable,      // stage 3 enabled
    output logic            temp_comp_enable,   // temperature compensation on
    output logic            time_limit_enable,  // charging time limits on
    output logic [9:0]      stage3_ratio        // stage3/stage2 limit, permille
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [2:0] fault_enc(input logic [3:0] f);
        if (f[0])
            return CRS_FLT_DISC;
        else if (f[1])
            return CRS_FLT_TEMP;
        else if (f[2])
            return CRS_FLT_TIMER;
        else if (f[3])
            return CRS_FLT_UVOLT;
        else
            return CRS_FLT_NONE;
    endfunction

    function automatic logic tick(input logic [31:0] c);
        return c == 32'h0;
    endfunction

    crs_state_t q, d;

    logic [2:0] fault_code;
    logic [2:0] stage_code;
    logic       hold_on;
    logic [7:0] status_byte;
    logic [2:0] n_stat;
    logic [2:0] n_flt;
    logic       low_power_flag;

    // ----------------------------------------
    // status decode
    // ----------------------------------------
    always_comb begin
        fault_code     = fault_enc(fault_in);
        hold_on        = done_in
                       | (stage_in == CRS_STG2[1:0] & ~q.cfg.stage3_en
                          & ~q.cfg.time_lim_en & iout_below_c10);
        low_power_flag = ~low_power_in;
        if (done_in)
            stage_code = CRS_STG_DONE;
        else if (hold_on)
            stage_code = CRS_STG2_LOW;
        else
            stage_code = {1'b0, stage_in};
        status_byte = {1'b0, low_power_flag, stage_code, fault_code};
        n_flt = fault_code;
        if (fault_code != CRS_FLT_NONE)
            n_stat = 3'h1;
        else
            n_stat = (stage_in == CRS_STG0[1:0]) ? 3'h1 : {1'b0, stage_in};
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        d = q;
        d.rdata = 32'h0;

        // registers
        if (reg_wr && reg_addr == CRS_REG_CTRL)
            d.en = reg_wdata[0];
        if (reg_rd) begin
            case (reg_addr)
                CRS_REG_CTRL: d.rdata = {31'h0, q.en};
                CRS_REG_STAT: d.rdata = {13'h0, q.s2_hold, q.restart, q.last,
                                         q.flt, q.stat, 4'h0, q.ph != CRS_IDLE, q.ph};
                default:      d.rdata = 32'h0;
            endcase
        end

        // configuration decode
        d.cfg.stage3_en    = charge_config_in_a >= CRS_CFG_LOW;
        d.cfg.temp_comp_en = charge_config_in_a >= CRS_CFG_LOW;
        d.cfg.wide_temp    = charge_config_in_b >= CRS_CFG_MID;
        d.cfg.time_lim_en  = charge_config_in_b >= CRS_CFG_LOW
                           && charge_config_in_b <= CRS_CFG_HIGH;
        d.s2_hold = stage_in == CRS_STG2[1:0] && !q.cfg.time_lim_en;
        d.restart = stage_in == CRS_STG3[1:0] && q.cfg.stage3_en && !q.cfg.time_lim_en
                  && (vbat_below_96 || iout_above_c5);

        // burst interval
        if (!charger_run || !q.en) begin
            d.burst = 32'(BURST_CYC - 1);
            d.ph    = CRS_IDLE;
            d.stat  = 1'b0;
            d.flt   = 1'b0;
            d.fleft = 3'h0;
        end else begin
            if (tick(q.burst))
                d.burst = 32'(BURST_CYC - 1);
            else
                d.burst = q.burst - 32'h1;

            // fault LED train, runs beside the status sequence
            if (tick(q.burst)) begin
                d.fleft = n_flt;
                d.flt   = n_flt != 3'h0;
                d.ftmr  = 32'(LONG_CYC - 1);
            end else if (q.fleft != 3'h0) begin
                if (tick(q.ftmr)) begin
                    d.ftmr = 32'(LONG_CYC - 1);
                    // rise again after each gap while pulses remain
                    d.flt  = ~q.flt;
                    if (q.flt)
                        d.fleft = q.fleft - 3'h1;
                end else begin
                    d.ftmr = q.ftmr - 32'h1;
                end
            end

            // status LED and serial sequence
            case (q.ph)
                CRS_IDLE: begin
                    d.stat = hold_on;
                    if (tick(q.burst)) begin
                        d.last  = status_byte;
                        d.sh    = {1'b1, status_byte, 1'b0,
                                   1'b1, CRS_SYNC_BYTE, 1'b0};
                        d.nbit  = CRS_FRAME_BITS;
                        d.baud  = 32'h0;
                        d.sent  = 1'b0;
                        d.width = (fault_code != CRS_FLT_NONE || stage_in == CRS_STG0[1:0])
                                ? 32'(SHORT_CYC) : 32'(LONG_CYC);
                        d.tmr   = d.width - 32'h1;
                        d.left  = n_stat - 3'h1;
                        if (hold_on) begin
                            d.ph   = CRS_UART;
                            d.left = 3'h0;
                        end else begin
                            d.ph   = CRS_PULSE;
                            d.stat = 1'b1;
                        end
                    end
                end
                CRS_PULSE: begin
                    if (tick(q.tmr)) begin
                        if (!q.sent) begin
                            d.ph   = CRS_UART;
                            d.stat = 1'b1;
                        end else begin
                            d.stat = 1'b0;
                            d.tmr  = q.width - 32'h1;
                            d.ph   = (q.left != 3'h0) ? CRS_GAP : CRS_IDLE;
                        end
                    end else begin
                        d.tmr = q.tmr - 32'h1;
                    end
                end
                CRS_UART: begin
                    // one shift register spans both frames, so the
                    // status byte follows the sync byte with no idle bit
                    if (tick(q.baud)) begin
                        if (q.nbit == 5'h0) begin
                            d.sent = 1'b1;
                            d.tmr  = q.width - 32'h1;
                            d.stat = hold_on;
                            if (q.left != 3'h0)
                                d.ph = CRS_GAP;
                            else
                                d.ph = CRS_IDLE;
                        end else begin
                            d.stat = q.sh[0];
                            d.sh   = {1'b1, q.sh[19:1]};
                            d.nbit = q.nbit - 5'h1;
                            d.baud = 32'(BIT_CYC - 1);
                        end
                    end else begin
                        d.baud = q.baud - 32'h1;
                    end
                end
                CRS_GAP: begin
                    d.stat = 1'b0;
                    if (tick(q.tmr)) begin
                        d.stat = 1'b1;
                        d.left = q.left - 3'h1;
                        d.tmr  = q.width - 32'h1;
                        d.ph   = CRS_PULSE;
                    end else begin
                        d.tmr = q.tmr - 32'h1;
                    end
                end
                default: d.ph = CRS_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            q       <= '0;
            q.ph    <= CRS_IDLE;
            q.en    <= 1'b1;
            q.burst <= 32'(BURST_CYC - 1);
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    always_comb begin
        reg_rdata         = q.rdata;
        status_out        = q.stat;
        fault_out         = q.flt;
        restart_req       = q.restart;
        stage2_hold       = q.s2_hold;
        wide_temp_range   = q.cfg.wide_temp;
        stage3_enable     = q.cfg.stage3_en;
        temp_comp_enable  = q.cfg.temp_comp_en;
        time_limit_enable = q.cfg.time_lim_en;
        stage3_ratio      = q.cfg.stage3_en ? CRS_S3_RATIO : 10'h0;
    end

endmodule

// file: dv/crs_reporter_properties.sv
`timescale 1ns/10ps
module crs_checker
    import crs_pkg::*;
#(
    parameter int LONG_CYC = 200
) (
    input wire logic       clock,              // clk
    input wire logic       sys_rst,            // reset
    input wire logic       charger_run,        // run
    input wire logic [1:0] stage_in,           // stage
    input wire logic       iout_above_c5,      // over C/5
    input wire logic       vbat_below_96,      // under 96 %
    input wire logic [7:0] charge_config_in_a, // cfg a
    input wire logic [7:0] charge_config_in_b, // cfg b
    input wire logic       fault_out,          // fault led
    input wire logic       restart_req,        // restart
    input wire logic       stage2_hold,        // hold
    input wire logic       wide_temp_range,    // wide
    input wire logic       stage3_enable,      // s3 on
    input wire logic       temp_comp_enable,   // comp on
    input wire logic       time_limit_enable,  // limits on
    input wire logic [9:0] stage3_ratio        // ratio
);
    // ----------------------------------------
    // fault run lengths, high and low
    // ----------------------------------------
    int hi_q;
    int lo_q;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            hi_q <= 0;
            lo_q <= 0;
        end else begin
            hi_q <= fault_out ? hi_q + 1 : 0;
            lo_q <= fault_out ? 0 : lo_q + 1;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    sequence ground_s;
        (charge_config_in_a == 8'h00 && charge_config_in_b == 8'h00)[*3];
    endsequence
    sequence lead_s;
        (charge_config_in_a == 8'hE0 && charge_config_in_b == 8'hFF)[*3];
    endsequence
    cfg_ground_a: assert property (ground_s |-> !wide_temp_range && !stage3_enable
        && !temp_comp_enable && !time_limit_enable) else $error("ground config wrong");
    lead_acid_a: assert property (lead_s |-> wide_temp_range && stage3_enable
        && temp_comp_enable && !time_limit_enable && stage3_ratio == CRS_S3_RATIO)
        else $error("lead acid config wrong");
    hold_set_a: assert property ((stage_in == 2'h2 && !time_limit_enable)[*2]
        |-> stage2_hold) else $error("stage 2 hold missing");
    hold_clear_a: assert property ((stage_in != 2'h2)[*2] |-> !stage2_hold)
        else $error("stage 2 hold stray");
    restart_set_a: assert property ((stage_in == 2'h3 && stage3_enable && !time_limit_enable
        && (vbat_below_96 || iout_above_c5))[*2] |-> restart_req) else $error("no restart");
    run_off_a: assert property (!charger_run |=> !fault_out)
        else $error("fault output while stopped");
    fault_width_a: assert property ($fell(fault_out) && $past(charger_run) && charger_run
        |-> hi_q == LONG_CYC) else $error("fault pulse width wrong");
    fault_gap_a: assert property ($rose(fault_out) |-> lo_q >= LONG_CYC)
        else $error("fault gap too short");
endmodule

bind crs_reporter crs_checker #(.LONG_CYC(LONG_CYC)) u_chk (.clock(clock),
    .sys_rst(sys_rst), .charger_run(charger_run), .stage_in(stage_in),
    .iout_above_c5(iout_above_c5), .vbat_below_96(vbat_below_96),
    .charge_config_in_a(charge_config_in_a), .charge_config_in_b(charge_config_in_b),
    .fault_out(fault_out), .restart_req(restart_req), .stage2_hold(stage2_hold),
    .wide_temp_range(wide_temp_range), .stage3_enable(stage3_enable),
    .temp_comp_enable(temp_comp_enable), .time_limit_enable(time_limit_enable),
    .stage3_ratio(stage3_ratio));

// file: dv/crs_uart_rx.sv
`timescale 1ns/10ps
module crs_uart_rx (
    input wire logic  clock,     // sample clock
    input wire logic  rx_line,   // serial line
    input wire logic  arm,       // expect two frames
    output logic [7:0] sync_byte, // first frame
    output logic [7:0] stat_byte, // accepted status byte
    output logic      stat_ok,   // status byte accepted
    output logic      stop_ok,   // all stop bits high
    output logic [1:0] got,      // frames seen
    output int        bit_len    // measured bit time
);
    logic [8:0] d;
    initial begin
        {sync_byte, stat_byte, stat_ok, stop_ok, got, bit_len} = '0;
        forever begin
            wait (arm);
            {stat_byte, stat_ok, got} = '0;
            stop_ok = 1'b1;
            for (int k = 0; k < 2; k++) begin
                @(negedge rx_line);
                // rate taken from the start bit of the sync frame
                if (k == 0) begin
                    bit_len = 0;
                    // count only clocks that still see the start bit low
                    while (!rx_line) begin
                        @(negedge clock);
                        if (!rx_line) bit_len++;
                    end
                end
                repeat (k ? bit_len + bit_len / 2 : bit_len / 2) @(negedge clock);
                for (int i = 0; i < 9; i++) begin
                    if (i != 0) repeat (bit_len) @(negedge clock);
                    d[i] = rx_line;
                end
                stop_ok = stop_ok & d[8];
                if (k == 0) sync_byte = d[7:0];
                else if (!d[7]) begin
                    stat_byte = d[7:0];
                    stat_ok = 1'b1;
                end
                got = 2'(k + 1);
            end
            wait (!arm);
        end
    end
endmodule

// file: dv/tb_crs_reporter.sv
`timescale 1ns/10ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin fails++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, a); end end
module tb_crs_reporter
    import crs_pkg::*;
;
    localparam int BC  = 2000;
    localparam int LC  = 200;
    localparam int WIN = BC + 1700; // four fault pulses and gaps end before the cut
    logic clock = 0, sys_rst = 1, charger_run = 0, done_in = 0, low_power_in = 0;
    logic iout_below_c10 = 0, iout_above_c5 = 0, vbat_below_96 = 0;
    logic reg_wr = 0, reg_rd = 0, arm = 0, rx_ok, rx_stop;
    logic [1:0] stage_in = 0, rx_got;
    logic [3:0] fault_in = 0, reg_addr = 0;
    logic [7:0] cfg_a = 0, cfg_b = 0, rx_sync, rx_stat;
    logic [31:0] reg_wdata = 0, reg_rdata, rd;
    logic status_out, fault_out, restart_req, stage2_hold, wide_t, s3_en, comp_en, lim_en;
    logic [9:0] ratio;
    int fails = 0, total_checks = 0, rx_bit, nhi = 0;
    always #2.5 clock = ~clock;
    crs_reporter #(.BURST_CYC(BC), .LONG_CYC(LC), .SHORT_CYC(20), .BIT_CYC(8)) DUT (
        .clock(clock), .sys_rst(sys_rst), .charger_run(charger_run), .stage_in(stage_in),
        .done_in(done_in), .fault_in(fault_in), .low_power_in(low_power_in),
        .iout_below_c10(iout_below_c10), .iout_above_c5(iout_above_c5),
        .vbat_below_96(vbat_below_96), .charge_config_in_a(cfg_a), .charge_config_in_b(cfg_b),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .status_out(status_out), .fault_out(fault_out),
        .restart_req(restart_req), .stage2_hold(stage2_hold), .wide_temp_range(wide_t),
        .stage3_enable(s3_en), .temp_comp_enable(comp_en), .time_limit_enable(lim_en),
        .stage3_ratio(ratio));
    crs_uart_rx u_rx (.clock(clock), .rx_line(status_out), .arm(arm), .sync_byte(rx_sync),
        .stat_byte(rx_stat), .stat_ok(rx_ok), .stop_ok(rx_stop), .got(rx_got), .bit_len(rx_bit));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic conclude;
        if (fails == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge clock);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        d = reg_rdata;
    endtask
    // one burst per call; counts long, short and fault runs on the pins
    task automatic run_case(input logic [1:0] st, input logic dn, input logic [3:0] flt,
        input logic lp, b10, a5, v96, input logic [7:0] ca, cb);
        int nl, ns, nf, bad, sl, fl, rt;
        logic s3, lim, held;
        logic [2:0] fc, sc;
        {nl, ns, nf, bad, sl, fl} = '0;
        rt = -1;
        s3 = ca >= 8'h0A;
        lim = cb >= 8'h0A && cb <= 8'hF5;
        held = dn || (st == 2'h2 && !s3 && !lim && b10);
        fc = flt[0] ? 3'h1 : flt[1] ? 3'h2 : flt[2] ? 3'h3 : flt[3] ? 3'h4 : 3'h0;
        sc = dn ? 3'h5 : held ? 3'h4 : {1'b0, st};
        @(posedge clock);
        {charger_run, arm, stage_in, done_in, fault_in} <= {2'b00, st, dn, flt};
        {low_power_in, iout_below_c10, iout_above_c5, vbat_below_96} <= {lp, b10, a5, v96};
        {cfg_a, cfg_b} <= {ca, cb};
        repeat (3) @(posedge clock);
        {charger_run, arm} <= 2'b11;
        for (int t = 0; t < WIN + 4; t++) begin
            @(posedge clock);
            if (t == WIN) charger_run <= 1'b0;
            @(negedge clock);
            if (t == BC / 2) begin
                `CHK("hold", st == 2'h2 && !lim, stage2_hold)
                `CHK("restart", st == 2'h3 && s3 && !lim && (v96 || a5), restart_req)
                `CHK("wide range", cb >= 8'h80, wide_t)
                `CHK("stage3 on", s3, s3_en)
                `CHK("comp on", s3, comp_en)
                `CHK("limits on", lim, lim_en)
                `CHK("ratio", s3 ? CRS_S3_RATIO : 10'h0, ratio)
            end
            if (status_out && sl == 0 && rt < 0) rt = t;
            if (status_out) sl++;
            else begin
                if (sl >= 150) nl++;
                if (sl >= 19 && sl <= 22) ns++;
                sl = 0;
            end
            if (fault_out) fl++;
            else begin
                if (fl == LC) nf++;
                else if (fl != 0) bad++;
                fl = 0;
            end
        end
        `CHK("long pulses", held ? 2 : (fc != 0 || st == 0) ? 0 : int'(st), nl)
        `CHK("short pulse", (!held && (fc != 0 || st == 0)) ? 1 : 0, ns)
        `CHK("burst start", held ? 0 : BC - 1, rt)
        `CHK("fault pulses", int'(fc), nf)
        `CHK("fault stray", 0, bad)
        `CHK("frames", 2'h2, rx_got)
        `CHK("bit time", 8, rx_bit)
        `CHK("sync byte", CRS_SYNC_BYTE, rx_sync)
        `CHK("stop bits", 1'b1, rx_stop)
        `CHK("status kept", 1'b1, rx_ok)
        `CHK("status byte", {1'b0, ~lp, sc, fc}, rx_stat)
    endtask
    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (90000) @(posedge clock);
        fails++;
        conclude();
    end
    initial begin
        void'($urandom(32'h29AD885E));
        repeat (12) @(posedge clock);
        sys_rst <= 1'b0;
        reg_read(CRS_REG_CTRL, rd);
        `CHK("ctrl reset", 32'h1, rd)
        reg_read(4'h8, rd);
        `CHK("unmapped", 32'h0, rd)
        for (int s = 0; s < 4; s++) run_case(2'(s), 0, 0, s[0], 0, 0, s == 3, 8'hE0, 8'hFF);
        for (int f = 0; f < 4; f++) run_case(2'h1, 0, 4'h1 << f, 0, 0, f[0], 0, 8'hE0, 8'hFF);
        run_case(2'h3, 0, 4'hE, 1, 0, 0, 0, 8'hE0, 8'hFF);
        run_case(2'h2, 1, 0, 0, 0, 0, 0, 8'hE0, 8'hFF);
        run_case(2'h2, 0, 0, 1, 1, 0, 0, 8'h00, 8'h00);
        run_case(2'h2, 0, 0, 0, 0, 1, 0, 8'h00, 8'h00);
        repeat (6) run_case(2'($urandom), 0, ($urandom & 1) ? 4'($urandom) : 4'h0,
            1'($urandom), 0, 1'($urandom), 1'($urandom), 8'($urandom), 8'($urandom));
        reg_write(CRS_REG_CTRL, 32'h0);
        charger_run <= 1'b1;
        for (int t = 0; t < BC + 300; t++) begin
            @(negedge clock);
            if (status_out !== 1'b0) nhi++;
        end
        `CHK("disabled quiet", 0, nhi)
        reg_read(CRS_REG_STAT, rd);
        `CHK("stat idle", 2'h0, rd[1:0])
        conclude();
    end
endmodule
